// ---- rtl/srb_map.svh ----
// Purpose: offsets, field positions and reset values of the serial port
// Assumes: word index = byte address / 4 on a 32-bit bus
// Notes: definitions only
`ifndef SRB_MAP_SVH
`define SRB_MAP_SVH
// ============================================================
// register indices
`define SRB_IDX_BAUD_HI 4'h0
`define SRB_IDX_BAUD_LO 4'h1
`define SRB_IDX_CTRL1 4'h2
`define SRB_IDX_CTRL2 4'h3
`define SRB_IDX_STAT1 4'h4
`define SRB_IDX_STAT2 4'h5
`define SRB_IDX_DATA_HI 4'h6
`define SRB_IDX_DATA_LO 4'h7
`define SRB_IDX_IRQ_STAT 4'h8
`define SRB_IDX_IRQ_MASK 4'h9
`define SRB_IDX_LAST 4'h9
// ============================================================
// field positions
`define SRB_BIT_IR_ON 7
`define SRB_BIT_BANK 7
`define SRB_BIT_TXE 3
`define SRB_BIT_RXE 2
`define SRB_BIT_T8 6
// ============================================================
// reset values and masks
`define SRB_RST_BAUD_LO 8'h04
`define SRB_RST_BYTE 8'h00
`define SRB_SR2_WMASK 8'h9e
`endif

// ---- rtl/srb_pkg.sv ----
// Purpose: types of the serial port register block
// Assumes: nothing
// Notes: one packed struct carries all module state except the gap_q and clean_q check registers
package srb_pkg;
    typedef enum logic [0:0] {
        SRB_BG_IDLE = 1'b0,
        SRB_BG_RUN = 1'b1
    } srb_bg_t;

    typedef struct packed {
        logic aw_v;
        logic [4:0] aw_dec;
        logic w_v;
        logic [7:0] w_data;
        logic w_be;
        logic bvalid;
        logic rvalid;
        logic [7:0] rdata;
        logic [7:0] hold;
        logic [7:0] bdh;
        logic [7:0] bdl;
        logic [7:0] cr1;
        logic [2:0] aflag;
        logic [2:0] aen;
        logic [2:0] ackz;
        logic [7:0] cr2;
        logic [7:0] sr2;
        logic t8;
        logic [7:0] tx_data;
        logic tx_wr;
        logic [1:0] ist;
        logic [1:0] imk;
        srb_bg_t bg;
        logic [12:0] cnt;
        logic tick;
        logic [3:0] pw;
    } srb_state_t;
endpackage

// ---- rtl/srb_top.sv ----
// Purpose: serial port register map and baud tick generator
// Assumes: axi4-lite slave, 32-bit data, frame logic on same clock
// Notes: byte address = index * 4, low byte lane only
`timescale 1ns/10ps
`include "srb_map.svh"
module srb_top #(
    parameter int ADDR_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic [7:0] main_status,
    input wire logic rx_ninth,
    input wire logic [7:0] rx_data,
    input wire logic rx_active,
    input wire logic [2:0] alt_event,
    input wire logic berr_value,
    output logic baud_tick,
    output logic infrared_enable,
    output logic [1:0] ir_pulse_width_sel,
    output logic [3:0] ir_pulse_32nds,
    output logic [7:0] line_format_ctrl,
    output logic [7:0] tx_rx_enable_ctrl,
    output logic [2:0] break_biterr_ctrl,
    output logic [3:0] polarity_ctrl,
    output logic [7:0] tx_data,
    output logic tx_ninth,
    output logic tx_data_wr,
    output logic irq
);
    import srb_pkg::*;

    // ============================================================
    // functions
    // {bad, index}; misaligned or beyond the map is bad
    function automatic logic [4:0] dec_fn(input logic [ADDR_W-1:0] a);
        logic [3:0] ix;
        logic bad;
        ix = a[5:2];
        bad = (|a[1:0]) || (ix > `SRB_IDX_LAST);
        if (ADDR_W > 6) begin
            bad = bad || (|(a >> 6));
        end
        return {bad, ix};
    endfunction

    // clocks between sampling ticks
    function automatic logic [12:0] per_fn(input logic [7:0] hi,
                                           input logic [7:0] lo);
        if (hi[`SRB_BIT_IR_ON]) begin
            return {hi[4:0], lo[7:1], 1'b0};
        end
        return {hi[4:0], lo};
    endfunction

    // narrow pulse in 1/32 bit units
    function automatic logic [3:0] pw_fn(input logic [1:0] code);
        case (code)
            2'b11: return 4'h8;
            2'b10: return 4'h1;
            2'b01: return 4'h2;
            default: return 4'h6;
        endcase
    endfunction

    // ============================================================
    // state
    srb_state_t s_q;
    srb_state_t s_d;
    logic [4:0] rd_dec;
    logic [12:0] per;
    logic bank;
    logic wr_go;
    logic [3:0] wr_idx;

    assign rd_dec = dec_fn(araddr);
    assign per = per_fn(s_q.bdh, s_q.bdl);
    assign bank = s_q.sr2[`SRB_BIT_BANK];
    assign wr_go = s_q.aw_v && s_q.w_v;
    assign wr_idx = s_q.aw_dec[3:0];

    // ============================================================
    // next state
    always_comb begin
        logic [7:0] wd;
        logic [7:0] rd;
        logic lo_wr;
        logic start;
        wd = s_q.w_data;
        rd = 8'h00;
        lo_wr = 1'b0;
        start = 1'b0;
        s_d = s_q;
        s_d.tick = 1'b0;
        s_d.tx_wr = 1'b0;
        if (s_q.bvalid && bready) begin
            s_d.bvalid = 1'b0;
        end
        if (s_q.rvalid && rready) begin
            s_d.rvalid = 1'b0;
        end
        if (awvalid && awready) begin
            s_d.aw_v = 1'b1;
            s_d.aw_dec = dec_fn(awaddr);
        end
        if (wvalid && wready) begin
            s_d.w_v = 1'b1;
            s_d.w_data = wdata[7:0];
            s_d.w_be = wstrb[0];
        end
        // clears first so that a same-cycle event still lands
        if (wr_go) begin
            s_d.aw_v = 1'b0;
            s_d.w_v = 1'b0;
            s_d.bvalid = 1'b1;
            if (!s_q.aw_dec[4] && s_q.w_be) begin
                case (wr_idx)
                    `SRB_IDX_BAUD_HI: begin
                        if (bank) begin
                            s_d.aflag = s_q.aflag & ~{wd[7], wd[1:0]};
                        end else begin
                            s_d.hold = wd;
                        end
                    end
                    `SRB_IDX_BAUD_LO: begin
                        if (bank) begin
                            s_d.aen = {wd[7], wd[1:0]};
                        end else begin
                            s_d.bdl = wd;
                            s_d.bdh = s_q.hold;
                            s_d.pw = pw_fn(s_q.hold[6:5]);
                            lo_wr = 1'b1;
                        end
                    end
                    `SRB_IDX_CTRL1: begin
                        if (bank) begin
                            s_d.ackz = wd[2:0];
                        end else begin
                            s_d.cr1 = wd;
                        end
                    end
                    `SRB_IDX_CTRL2: s_d.cr2 = wd;
                    `SRB_IDX_STAT2: s_d.sr2 = wd & `SRB_SR2_WMASK;
                    `SRB_IDX_DATA_HI: s_d.t8 = wd[`SRB_BIT_T8];
                    `SRB_IDX_DATA_LO: begin
                        s_d.tx_data = wd;
                        s_d.tx_wr = 1'b1;
                    end
                    `SRB_IDX_IRQ_STAT: s_d.ist = s_q.ist & ~wd[1:0];
                    `SRB_IDX_IRQ_MASK: s_d.imk = wd[1:0];
                    default: s_d.ist = s_d.ist;
                endcase
            end
        end
        s_d.aflag = s_d.aflag | alt_event;
        // read mux, sampled at the address handshake
        if (arvalid && arready) begin
            s_d.rvalid = 1'b1;
            if (!rd_dec[4]) begin
                case (rd_dec[3:0])
                    `SRB_IDX_BAUD_HI: rd = bank ?
                        {s_q.aflag[2], 4'h0, berr_value, s_q.aflag[1:0]} :
                        s_q.bdh;
                    `SRB_IDX_BAUD_LO: rd = bank ?
                        {s_q.aen[2], 5'h00, s_q.aen[1:0]} : s_q.bdl;
                    `SRB_IDX_CTRL1: rd = bank ?
                        {5'h00, s_q.ackz} : s_q.cr1;
                    `SRB_IDX_CTRL2: rd = s_q.cr2;
                    `SRB_IDX_STAT1: rd = main_status;
                    `SRB_IDX_STAT2: rd = s_q.sr2 | {7'h00, rx_active};
                    `SRB_IDX_DATA_HI: rd = {rx_ninth, s_q.t8, 6'h00};
                    `SRB_IDX_DATA_LO: rd = rx_data;
                    `SRB_IDX_IRQ_STAT: rd = {6'h00, s_q.ist};
                    `SRB_IDX_IRQ_MASK: rd = {6'h00, s_q.imk};
                    default: rd = 8'h00;
                endcase
            end
            s_d.rdata = rd;
        end
        // baud generator; runs off the live divisor only
        case (s_q.bg)
            SRB_BG_IDLE: begin
                s_d.cnt = 13'h0000;
                if (s_q.cr2[`SRB_BIT_TXE] || s_q.cr2[`SRB_BIT_RXE]) begin
                    s_d.bg = SRB_BG_RUN;
                    start = 1'b1;
                end
            end
            SRB_BG_RUN: begin
                if (per == 13'h0000) begin
                    s_d.cnt = 13'h0000;
                end else if (s_q.cnt >= per - 13'h0001) begin
                    s_d.cnt = 13'h0000;
                    s_d.tick = 1'b1;
                end else begin
                    s_d.cnt = s_q.cnt + 13'h0001;
                end
            end
            default: s_d.bg = SRB_BG_IDLE;
        endcase
        s_d.ist = s_d.ist | {lo_wr, start};
    end

    // ============================================================
    // registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
            s_q.bdl <= `SRB_RST_BAUD_LO;
            s_q.bg <= SRB_BG_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // ============================================================
    // outputs
    assign awready = !s_q.aw_v && !s_q.bvalid;
    assign wready = !s_q.w_v && !s_q.bvalid;
    assign arready = !s_q.rvalid;
    assign bvalid = s_q.bvalid;
    assign bresp = 2'b00;
    assign rvalid = s_q.rvalid;
    assign rresp = 2'b00;
    assign rdata = {24'h000000, s_q.rdata};
    assign baud_tick = s_q.tick;
    assign infrared_enable = s_q.bdh[`SRB_BIT_IR_ON];
    assign ir_pulse_width_sel = s_q.bdh[6:5];
    assign ir_pulse_32nds = s_q.pw;
    assign line_format_ctrl = s_q.cr1;
    assign tx_rx_enable_ctrl = s_q.cr2;
    assign break_biterr_ctrl = s_q.ackz;
    assign polarity_ctrl = s_q.sr2[4:1];
    assign tx_data = s_q.tx_data;
    assign tx_ninth = s_q.t8;
    assign tx_data_wr = s_q.tx_wr;
    // alternative flags share the line through their own enables
    assign irq = (|(s_q.ist & s_q.imk)) || (|(s_q.aflag & s_q.aen));

    // ============================================================
    // checks
    logic [12:0] gap_q;
    logic clean_q;
    logic [12:0] div;
    logic lo_go;
    logic hi_go;

    assign div = {s_q.bdh[4:0], s_q.bdl};
    assign lo_go = wr_go && !s_q.aw_dec[4] && s_q.w_be && !bank &&
                   (wr_idx == `SRB_IDX_BAUD_LO);
    assign hi_go = wr_go && !s_q.aw_dec[4] && s_q.w_be && !bank &&
                   (wr_idx == `SRB_IDX_BAUD_HI);

    // gap is only trusted once a tick has followed the last write to any register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gap_q <= 13'h0000;
            clean_q <= 1'b0;
        end else begin
            gap_q <= baud_tick ? 13'h0001 : gap_q + 13'h0001;
            if (wr_go) begin
                clean_q <= 1'b0;
            end else if (baud_tick) begin
                clean_q <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    property p_bad_rd_zero;
        (arvalid && arready && rd_dec[4]) |=> (rdata == 32'h00000000);
    endproperty
    a_bad_rd_zero: assert property (p_bad_rd_zero)
        else $error("unmapped read not zero");

    property p_bad_wr_ign;
        (wr_go && s_q.aw_dec[4]) |=>
            ($stable(s_q.bdl) && $stable(s_q.hold) && $stable(s_q.cr2));
    endproperty
    a_bad_wr_ign: assert property (p_bad_wr_ign)
        else $error("unmapped write changed state");

    property p_hi_staged;
        hi_go |=> ($stable(div) && s_q.hold == $past(s_q.w_data));
    endproperty
    a_hi_staged: assert property (p_hi_staged)
        else $error("high write reached divisor");

    property p_lo_commit;
        lo_go |=> (div == {$past(s_q.hold[4:0]), $past(s_q.w_data)});
    endproperty
    a_lo_commit: assert property (p_lo_commit)
        else $error("divisor not committed");

    property p_bank_alt;
        (arvalid && arready && !rd_dec[4] && bank &&
         rd_dec[3:0] == `SRB_IDX_BAUD_LO) |=>
            (rdata[7:0] == {$past(s_q.aen[2]), 5'h00, $past(s_q.aen[1:0])});
    endproperty
    a_bank_alt: assert property (p_bank_alt)
        else $error("alternate bank read wrong");

    property p_bank_base;
        (arvalid && arready && !rd_dec[4] && !bank &&
         rd_dec[3:0] == `SRB_IDX_CTRL1) |=>
            (rdata[7:0] == $past(s_q.cr1));
    endproperty
    a_bank_base: assert property (p_bank_base)
        else $error("base bank read wrong");

    property p_rst_val;
        disable iff (1'b0)
        !aresetn |=> (s_q.bdl == `SRB_RST_BAUD_LO && s_q.bg == SRB_BG_IDLE);
    endproperty
    a_rst_val: assert property (p_rst_val)
        else $error("reset state wrong");

    property p_idle_quiet;
        (s_q.bg == SRB_BG_IDLE) |=> !baud_tick;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("tick while idle");

    property p_start;
        (s_q.bg == SRB_BG_IDLE && (s_q.cr2[3] || s_q.cr2[2])) |=>
            (s_q.bg == SRB_BG_RUN && s_q.ist[0]);
    endproperty
    a_start: assert property (p_start)
        else $error("generator did not start");

    property p_zero_off;
        (per == 13'h0000) |=> !baud_tick;
    endproperty
    a_zero_off: assert property (p_zero_off)
        else $error("tick with zero divisor");

    property p_gap_std;
        (baud_tick && clean_q && !infrared_enable) |-> (gap_q == div);
    endproperty
    a_gap_std: assert property (p_gap_std)
        else $error("tick spacing wrong");

    property p_gap_ir;
        (baud_tick && clean_q && infrared_enable) |->
            (gap_q == {div[12:1], 1'b0});
    endproperty
    a_gap_ir: assert property (p_gap_ir)
        else $error("infrared tick spacing wrong");

    property p_pw;
        lo_go |=> (ir_pulse_32nds == pw_fn($past(s_q.hold[6:5])));
    endproperty
    a_pw: assert property (p_pw)
        else $error("pulse width wrong");

    c_tick: cover property (baud_tick && clean_q);
    c_ir_tick: cover property (baud_tick && infrared_enable);
    c_bank: cover property ($rose(bank));
endmodule

// ---- test/srb_peer_model.sv ----
// Purpose: far-side model feeding frame status into the register block
// Assumes: one clock, the peer echoes every byte sent to it
// Notes: status levels fixed; only the echoed byte and edge pulse move
`timescale 1ns/10ps
module srb_peer_model #(
    parameter logic [7:0] STATUS = 8'hc0
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic tx_data_wr,
    input wire logic [7:0] tx_data,
    output logic [7:0] main_status,
    output logic rx_ninth,
    output logic [7:0] rx_data,
    output logic rx_active,
    output logic [2:0] alt_event,
    output logic berr_value
);
    // ============================================================
    // echo peer
    assign main_status = STATUS;
    assign rx_ninth = 1'b0;
    assign rx_active = 1'b1;
    assign berr_value = 1'b0;
    // a returned byte also shows as an active receive edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_data <= 8'h00;
            alt_event <= 3'h0;
        end else begin
            alt_event <= {tx_data_wr, 2'b00};
            if (tx_data_wr) begin
                rx_data <= tx_data;
            end
        end
    end
endmodule

// ---- test/serial_port_regs_baud_tb_top.sv ----
// Purpose: self-checking bench of the register map and baud ticks
// Assumes: byte address = index * 4, mask bit set lets a status bit through
// Notes: tick counts taken over whole periods after settling
`timescale 1ns/10ps
`include "srb_map.svh"
module serial_port_regs_baud_tb_top;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb, ir_pulse_32nds, polarity_ctrl;
    logic awready, wready, bvalid, arready, rvalid, baud_tick;
    logic [1:0] bresp, rresp, ir_pulse_width_sel;
    logic infrared_enable, tx_ninth, tx_data_wr, irq;
    logic [7:0] line_format_ctrl, tx_rx_enable_ctrl, tx_data;
    logic [2:0] break_biterr_ctrl, alt_event;
    logic [7:0] main_status, rx_data;
    logic rx_ninth, rx_active, berr_value;
    logic [3:0] pw_tbl [4] = '{4'h6, 4'h2, 4'h1, 4'h8};
    int fails = 0;
    int checked = 0;
    int c;
    // ============================================================
    // instances
    srb_top i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awprot(3'h0), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .main_status(main_status),
        .rx_ninth(rx_ninth), .rx_data(rx_data), .rx_active(rx_active),
        .alt_event(alt_event), .berr_value(berr_value),
        .baud_tick(baud_tick), .infrared_enable(infrared_enable),
        .ir_pulse_width_sel(ir_pulse_width_sel),
        .ir_pulse_32nds(ir_pulse_32nds),
        .line_format_ctrl(line_format_ctrl),
        .tx_rx_enable_ctrl(tx_rx_enable_ctrl),
        .break_biterr_ctrl(break_biterr_ctrl),
        .polarity_ctrl(polarity_ctrl), .tx_data(tx_data),
        .tx_ninth(tx_ninth), .tx_data_wr(tx_data_wr), .irq(irq));
    srb_peer_model i_peer (.aclk(aclk), .aresetn(aresetn),
        .tx_data_wr(tx_data_wr), .tx_data(tx_data),
        .main_status(main_status), .rx_ninth(rx_ninth),
        .rx_data(rx_data), .rx_active(rx_active),
        .alt_event(alt_event), .berr_value(berr_value));
    always #10 aclk = ~aclk;
    // ============================================================
    // shared tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] i, input logic [7:0] d);
        logic [1:0] resp;
        resp = 2'b11;
        @(posedge aclk);
        awaddr <= {2'b00, i, 2'b00};
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                resp = bresp;
                break;
            end
        end
        bready <= 1'b0;
        chk(resp, 2'b00);
    endtask
    task automatic rdchk(input logic [3:0] i, input logic [7:0] e);
        logic [31:0] d;
        logic [1:0] resp;
        resp = 2'b11;
        @(posedge aclk);
        araddr <= {2'b00, i, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                d = rdata;
                resp = rresp;
                break;
            end
        end
        rready <= 1'b0;
        chk(resp, 2'b00);
        chk(d, {24'h0, e});
    endtask
    // counts over n cycles; checked counts use whole periods, settling calls need not
    task automatic ticks(input int n, output int t);
        t = 0;
        repeat (n) begin
            @(posedge aclk);
            if (baud_tick === 1'b1) t++;
        end
    endtask
    task end_of_test;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // ============================================================
    // scenarios
    task t_reset;
        rdchk(`SRB_IDX_BAUD_LO, 8'h04);
        rdchk(`SRB_IDX_BAUD_HI, 8'h00);
        rdchk(`SRB_IDX_STAT1, 8'hc0);
        wr(4'hf, 8'hff);
        rdchk(4'hf, 8'h00);
        ticks(32, c);
        chk(c, 0);
    endtask
    task t_baud;
        wr(`SRB_IDX_CTRL2, 8'h08);
        chk(tx_rx_enable_ctrl, 8'h08);
        ticks(8, c);
        ticks(64, c);
        chk(c, 16);
        wr(`SRB_IDX_BAUD_HI, 8'h80);
        chk(infrared_enable, 1'b0);
        rdchk(`SRB_IDX_BAUD_HI, 8'h00);
        wr(`SRB_IDX_BAUD_LO, 8'h07);
        rdchk(`SRB_IDX_BAUD_HI, 8'h80);
        chk(infrared_enable, 1'b1);
        ticks(8, c);
        ticks(60, c);
        chk(c, 10);
        // growing periods only, so the free counter never overshoots
        wr(`SRB_IDX_BAUD_HI, 8'h01);
        wr(`SRB_IDX_BAUD_LO, 8'h00);
        ticks(260, c);
        ticks(512, c);
        chk(c, 2);
        wr(`SRB_IDX_BAUD_HI, 8'h80);
        wr(`SRB_IDX_BAUD_LO, 8'h01);
        ticks(300, c);
        chk(c, 0);
        wr(`SRB_IDX_BAUD_HI, 8'h00);
        wr(`SRB_IDX_BAUD_LO, 8'h00);
        ticks(300, c);
        chk(c, 0);
    endtask
    task t_pulse;
        for (int k = 0; k < 4; k++) begin
            wr(`SRB_IDX_BAUD_HI, {1'b0, k[1:0], 5'h00});
            wr(`SRB_IDX_BAUD_LO, 8'h04);
            chk(ir_pulse_width_sel, k[1:0]);
            chk(ir_pulse_32nds, pw_tbl[k]);
        end
    endtask
    task t_irq;
        // mask bit set passes the status bit to the line
        rdchk(`SRB_IDX_IRQ_STAT, 8'h03);
        chk(irq, 1'b0);
        wr(`SRB_IDX_IRQ_MASK, 8'h02);
        chk(irq, 1'b1);
        wr(`SRB_IDX_IRQ_MASK, 8'h01);
        chk(irq, 1'b1);
        rdchk(`SRB_IDX_IRQ_MASK, 8'h01);
        wr(`SRB_IDX_IRQ_STAT, 8'h01);
        chk(irq, 1'b0);
        rdchk(`SRB_IDX_IRQ_STAT, 8'h02);
    endtask
    task t_bank;
        wr(`SRB_IDX_CTRL1, 8'h5a);
        chk(line_format_ctrl, 8'h5a);
        wr(`SRB_IDX_DATA_LO, 8'h3c);
        chk(tx_data, 8'h3c);
        rdchk(`SRB_IDX_DATA_LO, 8'h3c);
        wr(`SRB_IDX_DATA_HI, 8'hff);
        chk(tx_ninth, 1'b1);
        rdchk(`SRB_IDX_DATA_HI, 8'h40);
        wr(`SRB_IDX_STAT2, 8'h9f);
        rdchk(`SRB_IDX_STAT2, 8'h9f);
        chk(polarity_ctrl, 4'hf);
        rdchk(`SRB_IDX_BAUD_HI, 8'h80);
        wr(`SRB_IDX_BAUD_LO, 8'h81);
        rdchk(`SRB_IDX_BAUD_LO, 8'h81);
        chk(irq, 1'b1);
        wr(`SRB_IDX_BAUD_HI, 8'h80);
        chk(irq, 1'b0);
        wr(`SRB_IDX_CTRL1, 8'h07);
        chk(break_biterr_ctrl, 3'h7);
        rdchk(`SRB_IDX_CTRL1, 8'h07);
        wr(`SRB_IDX_STAT2, 8'h00);
        rdchk(`SRB_IDX_BAUD_LO, 8'h04);
        rdchk(`SRB_IDX_CTRL1, 8'h5a);
        ticks(64, c);
        chk(c, 16);
    endtask
    // ============================================================
    // main sequence and watchdog
    initial begin
        aclk = 1'b0;
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        wstrb = 4'h1;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset;
        t_baud;
        t_pulse;
        t_irq;
        t_bank;
        end_of_test;
    end
    initial begin
        #400000;
        fails++;
        end_of_test;
    end
endmodule
